// [hdl/dio_routing.sv]
// Purpose: digital input and output stage of a motor controller
// Assumes: pins synchronous to clk_sys_in; registers reached over apb
// Notes:   outputs are open drain, enable high pulls the pin low
// What this block does
// - routing enable makes each summary bit come from a selectable source
// - inputs sampled once per millisecond; shorter pulses are seen only if one spans a sample
// - with input routing on, the summary ignores special enable, invert and force
// - enabling input routing preloads table to reproduce previous mapping as if no force were enabled
// - routing entry n drives summary bit n
// - codes 00 zero, 01-10 inputs, 41-46 hall/encoder, 48 network active
// - adding 80 inverts the base source; 80 is constant one
// - interlock bit 3 one permits motion, zero forces fault reaction
// - interlock acts only when special enable bit 3 is set
// - output word bit 16 drives output 1, upward; low bits special
// - output word bit 0 drives the brake output
// - invert bit set makes a one drive a low level
// - manual enable bit takes that output from manual value
// - manual value holds the level for manually controlled outputs
// - the applied output pattern is readable
// - writing one to output routing enable switches to routed outputs
// - led bit 0 enables green, bit 1 red; cleared keeps led off
// - routed output carries its source gated by a control bit
// - routing entry source in bits 15 to 8
// - routing entry control index in bits 4 to 0, bit 7 inverts the control bit
// - with output routing on, invert and manual settings are ignored
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module dio_routing #(
   parameter int SAMPLE_CYC = dio_pkg::SAMPLE_CYCLES,
   parameter int N_IN       = dio_pkg::NUM_IN,
   parameter int N_OUT      = dio_pkg::NUM_OUT
) (
   // clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_b_in,
   // apb slave
   input  wire dio_pkg::apb_req_t    apb_in,
   output dio_pkg::apb_rsp_t         apb_out,
   // pins and status sources
   input  wire logic [15:0]          pins_in,
   input  wire dio_pkg::aux_sig_t    aux_in,
   input  wire logic                 fault_in,
   // outputs
   output logic [3:0]                pin_oe_out,
   output logic                      brake_out,
   output logic                      motion_ok_out,
   output logic                      fault_react_out,
   output logic                      led_green_out,
   output logic                      led_red_out
);
   import dio_pkg::*;

   typedef struct packed {
      logic [31:0]   tick_cnt;
      logic [9:0]    led_cnt;
      logic          led_phase;
      logic [15:0]   in_sampled;
      aux_sig_t      aux_sampled;
      logic [31:0]   in_special_en;
      logic [31:0]   in_invert;
      logic [31:0]   in_force_en;
      logic [31:0]   in_force_val;
      logic          in_route_en;
      logic [31:0]   summary;
      logic [31:0]   out_word;
      logic [31:0]   out_invert;
      logic [31:0]   out_man_en;
      logic [31:0]   out_man_val;
      logic          out_route_en;
      logic [1:0]    led_ctrl;
      logic [31:0]   applied;
      logic [3:0]    pin_oe;
      logic          brake;
      logic          motion_ok;
      logic          fault_react;
      logic          led_g;
      logic          led_r;
      apb_rsp_t      rsp;
   } state_t;

   state_t        q;
   state_t        next_q;
   logic [7:0]    in_route [NUM_ROUTE];
   logic [15:0]   out_route [N_OUT];
   logic [31:0]   routed_bits;
   logic [N_OUT-1:0] routed_out;
   logic [31:0]   fixed_bits;
   logic          tick;
   logic          wr_acc;
   logic          rd_acc;
   logic [11:0]   addr;

   assign addr   = apb_in.paddr;
   assign wr_acc = apb_in.psel && apb_in.penable && apb_in.pwrite;
   assign rd_acc = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
   assign tick   = (q.tick_cnt == 32'(SAMPLE_CYC - 1));

   // entry n selects summary bit n
   genvar g;
   generate
      for (g = 0; g < NUM_ROUTE; g++) begin : g_in
         dio_in_select u_sel (
            .code_in (in_route[g]),
            .phys_in (q.in_sampled),
            .aux_in  (q.aux_sampled),
            .bit_out (routed_bits[g])
         );
      end
      for (g = 0; g < N_OUT; g++) begin : g_out
         dio_out_route u_rt (
            .entry_in    (out_route[g]),
            .out_word_in (q.out_word),
            .pwm_in      (q.aux_sampled.pwm),
            .level_out   (routed_out[g])
         );
      end
   endgenerate

   // fixed mapping: level bits and special bits with invert/force
   always_comb begin
      logic [15:0] lv;
      lv = (q.in_sampled & ~q.in_force_en[15:0]) | (q.in_force_val[15:0] & q.in_force_en[15:0]);
      lv = lv ^ q.in_invert[15:0];
      fixed_bits = {lv, lv & q.in_special_en[15:0]};
   end

   // routing tables written over apb; preload on enabling routing
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < NUM_ROUTE; i++) begin
            in_route[i] <= SRC_ZERO;
         end
         for (int i = 0; i < N_OUT; i++) begin
            out_route[i] <= 16'hffff;
         end
      end else begin
         if (wr_acc && addr == OFF_IN_ROUTING_EN && apb_in.pwdata[0] && !q.in_route_en) begin
            for (int i = 0; i < NUM_ROUTE; i++) begin
               in_route[i] <= fixed_bits[i] ? SRC_INV : SRC_ZERO;
            end
            for (int i = 0; i < N_IN && i < 16; i++) begin
               in_route[LEVEL_BASE + i] <= 8'(i + 1) | (q.in_invert[i] ? SRC_INV : 8'h00);
               if (q.in_special_en[i]) begin
                  in_route[i] <= 8'(i + 1) | (q.in_invert[i] ? SRC_INV : 8'h00);
               end
            end
         end else if (wr_acc && addr[11:8] == OFF_IN_ROUTE_BASE[11:8] && addr[7] == 1'b0) begin
            in_route[addr[6:2]] <= apb_in.pwdata[7:0];
         end
         if (wr_acc && addr[11:8] == OFF_OUT_ROUTE_BASE[11:8] && addr[7:2] < 6'(N_OUT)) begin
            out_route[addr[3:2]] <= apb_in.pwdata[15:0];
         end
      end
   end

   always_comb begin
      logic [31:0] drive;
      logic        intl_en;
      next_q = q;
      drive  = 32'h0;
      intl_en = 1'b0;
      next_q.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;
      if (tick) begin
         next_q.in_sampled  = pins_in;
         next_q.aux_sampled = aux_in;
         next_q.summary = q.in_route_en ? routed_bits : fixed_bits;
         next_q.led_cnt = (q.led_cnt == 10'(LED_SAMPLES - 1)) ? 10'h0 : q.led_cnt + 10'h1;
         if (q.led_cnt == 10'(LED_SAMPLES - 1)) begin
            next_q.led_phase = ~q.led_phase;
         end
      end
      // interlock only with special enable bit 3
      intl_en = q.in_special_en[BIT_INTERLOCK];
      next_q.motion_ok   = !intl_en || q.summary[BIT_INTERLOCK];
      next_q.fault_react = intl_en && !q.summary[BIT_INTERLOCK];
      next_q.led_g = q.led_ctrl[0] && !fault_in && q.led_phase;
      next_q.led_r = q.led_ctrl[1] && fault_in && q.led_phase;

      // output computation
      if (q.out_route_en) begin
         drive = q.out_word;
         drive[LEVEL_BASE +: N_OUT] = routed_out;
      end else begin
         drive = q.out_word ^ q.out_invert;
         drive = (drive & ~q.out_man_en) | (q.out_man_val & q.out_man_en);
      end
      next_q.pin_oe  = ~drive[LEVEL_BASE +: N_OUT];
      next_q.brake   = drive[BIT_BRAKE];
      next_q.applied = drive;

      // apb
      next_q.rsp.pready  = apb_in.psel && !apb_in.penable;
      next_q.rsp.pslverr = 1'b0;
      if (rd_acc) begin
         case (addr)
            OFF_IN_SPECIAL_EN:  next_q.rsp.prdata = q.in_special_en;
            OFF_IN_INVERT:      next_q.rsp.prdata = q.in_invert;
            OFF_IN_FORCE_EN:    next_q.rsp.prdata = q.in_force_en;
            OFF_IN_FORCE_VAL:   next_q.rsp.prdata = q.in_force_val;
            OFF_IN_ROUTING_EN:  next_q.rsp.prdata = {31'h0, q.in_route_en};
            OFF_IN_SUMMARY:     next_q.rsp.prdata = q.summary;
            OFF_OUT_WORD:       next_q.rsp.prdata = q.out_word;
            OFF_OUT_INVERT:     next_q.rsp.prdata = q.out_invert;
            OFF_OUT_MAN_EN:     next_q.rsp.prdata = q.out_man_en;
            OFF_OUT_MAN_VAL:    next_q.rsp.prdata = q.out_man_val;
            OFF_OUT_APPLIED:    next_q.rsp.prdata = q.applied;
            OFF_OUT_ROUTING_EN: next_q.rsp.prdata = {31'h0, q.out_route_en};
            OFF_LED_CTRL:       next_q.rsp.prdata = {30'h0, q.led_ctrl};
            OFF_STATUS:         next_q.rsp.prdata = {30'h0, q.fault_react, q.motion_ok};
            default: begin
               if (addr[11:8] == OFF_IN_ROUTE_BASE[11:8] && addr[7] == 1'b0) begin
                  next_q.rsp.prdata = {24'h0, in_route[addr[6:2]]};
               end else if (addr[11:8] == OFF_OUT_ROUTE_BASE[11:8] && addr[7:2] < 6'(N_OUT)) begin
                  next_q.rsp.prdata = {16'h0, out_route[addr[3:2]]};
               end else begin
                  next_q.rsp.prdata  = 32'h0;
                  next_q.rsp.pslverr = 1'b1;
               end
            end
         endcase
      end
      if (wr_acc) begin
         case (addr)
            OFF_IN_SPECIAL_EN:  next_q.in_special_en = apb_in.pwdata;
            OFF_IN_INVERT:      next_q.in_invert     = apb_in.pwdata;
            OFF_IN_FORCE_EN:    next_q.in_force_en   = apb_in.pwdata;
            OFF_IN_FORCE_VAL:   next_q.in_force_val  = apb_in.pwdata;
            OFF_IN_ROUTING_EN:  next_q.in_route_en   = apb_in.pwdata[0];
            OFF_OUT_WORD:       next_q.out_word      = apb_in.pwdata;
            OFF_OUT_INVERT:     next_q.out_invert    = apb_in.pwdata;
            OFF_OUT_MAN_EN:     next_q.out_man_en    = apb_in.pwdata;
            OFF_OUT_MAN_VAL:    next_q.out_man_val   = apb_in.pwdata;
            OFF_OUT_ROUTING_EN: next_q.out_route_en  = apb_in.pwdata[0];
            OFF_LED_CTRL:       next_q.led_ctrl      = apb_in.pwdata[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= '0;
         q.pin_oe    <= '1;
         q.motion_ok <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign apb_out         = q.rsp;
   assign pin_oe_out      = q.pin_oe;
   assign brake_out       = q.brake;
   assign motion_ok_out   = q.motion_ok;
   assign fault_react_out = q.fault_react;
   assign led_green_out   = q.led_g;
   assign led_red_out     = q.led_r;

   // named steps shared by the checks below
   sequence s_route_enable_write;
      wr_acc && addr == OFF_IN_ROUTING_EN && apb_in.pwdata[0] && !q.in_route_en;
   endsequence
   sequence s_applied_read_setup;
      rd_acc && addr == OFF_OUT_APPLIED;
   endsequence
   sequence s_out_routed;
      q.out_route_en;
   endsequence

   AST_TICK_SPACING: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in) tick |=> !tick)
      else $error("sample tick repeated");
   AST_INTERLOCK_FAULT: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (q.in_special_en[BIT_INTERLOCK] && !q.summary[BIT_INTERLOCK]) |=> fault_react_out)
      else $error("interlock fault missing");
   AST_INTERLOCK_RELEASE: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (q.in_special_en[BIT_INTERLOCK] && q.summary[BIT_INTERLOCK]) |=>
      (motion_ok_out && !fault_react_out))
      else $error("interlock release lost");
   AST_INTERLOCK_GATE: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !q.in_special_en[BIT_INTERLOCK] |=> motion_ok_out)
      else $error("interlock acted");
   AST_BRAKE: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!q.out_route_en && !q.out_man_en[BIT_BRAKE]) |=>
      brake_out == ($past(q.out_word[BIT_BRAKE]) ^ $past(q.out_invert[BIT_BRAKE])))
      else $error("brake mismatch");
   AST_MANUAL: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (!q.out_route_en && q.out_man_en[BIT_BRAKE]) |=>
      brake_out == $past(q.out_man_val[BIT_BRAKE]))
      else $error("manual override lost");
   AST_APPLIED: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      pin_oe_out == ~q.applied[LEVEL_BASE +: N_OUT])
      else $error("status differs from pins");
   AST_SUMMARY: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (tick && q.in_route_en) |=> q.summary == $past(routed_bits))
      else $error("summary stale");
   AST_LED_OFF: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !q.led_ctrl[0] |=> !led_green_out)
      else $error("green led on while disabled");
   AST_RED_OFF: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !q.led_ctrl[1] |=> !led_red_out)
      else $error("red led on while disabled");
   // input 1 level keeps its source
   AST_PRELOAD: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      s_route_enable_write |=>
      in_route[LEVEL_BASE] == (8'h01 | ($past(q.in_invert[0]) ? SRC_INV : SRC_ZERO)))
      else $error("routing table not preloaded");
   AST_STATUS_READ: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      s_applied_read_setup |=> apb_out.pready && apb_out.prdata == $past(q.applied))
      else $error("applied status read wrong");
   AST_ROUTED_PINS: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      s_out_routed |=> pin_oe_out == ~$past(routed_out))
      else $error("routed output lost");
   AST_ROUTED_BRAKE: assert property (
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      s_out_routed |=> brake_out == $past(q.out_word[BIT_BRAKE]))
      else $error("routed brake overridden");
endmodule

// [hdl/dio_pkg.sv]
// Purpose: shared constants and carriers for the digital io routing stage
// Assumes: 32-bit apb register bus, 125 MHz system clock
// Notes:   register offsets are byte addresses of aligned words
package dio_pkg;
   localparam int CLK_HZ            = 125_000_000;
   localparam int SAMPLE_PERIOD_US  = 1000;
   localparam int SAMPLE_CYCLES     = CLK_HZ / 1_000_000 * SAMPLE_PERIOD_US;
   localparam int LED_PERIOD_MS     = 500;
   localparam int LED_SAMPLES       = LED_PERIOD_MS;
   localparam int NUM_IN            = 16;
   localparam int NUM_OUT           = 4;
   localparam int NUM_ROUTE         = 32;

   // register byte offsets
   localparam logic [11:0] OFF_IN_SPECIAL_EN   = 12'h000;
   localparam logic [11:0] OFF_IN_INVERT       = 12'h004;
   localparam logic [11:0] OFF_IN_FORCE_EN     = 12'h008;
   localparam logic [11:0] OFF_IN_FORCE_VAL    = 12'h00c;
   localparam logic [11:0] OFF_IN_ROUTING_EN   = 12'h010;
   localparam logic [11:0] OFF_IN_SUMMARY      = 12'h014;
   localparam logic [11:0] OFF_OUT_WORD        = 12'h020;
   localparam logic [11:0] OFF_OUT_UNUSED      = 12'h024;
   localparam logic [11:0] OFF_OUT_INVERT      = 12'h028;
   localparam logic [11:0] OFF_OUT_MAN_EN      = 12'h02c;
   localparam logic [11:0] OFF_OUT_MAN_VAL     = 12'h030;
   localparam logic [11:0] OFF_OUT_APPLIED     = 12'h034;
   localparam logic [11:0] OFF_OUT_ROUTING_EN  = 12'h038;
   localparam logic [11:0] OFF_LED_CTRL        = 12'h03c;
   localparam logic [11:0] OFF_STATUS          = 12'h040;
   localparam logic [11:0] OFF_IN_ROUTE_BASE   = 12'h100;
   localparam logic [11:0] OFF_OUT_ROUTE_BASE  = 12'h200;

   // source codes for input routing
   localparam logic [7:0] SRC_ZERO      = 8'h00;
   localparam logic [7:0] SRC_PHYS_LAST = 8'h10;
   localparam logic [7:0] SRC_HALL_U    = 8'h41;
   localparam logic [7:0] SRC_ENC_IDX   = 8'h46;
   localparam logic [7:0] SRC_NET       = 8'h48;
   localparam logic [7:0] SRC_INV       = 8'h80;
   localparam logic [7:0] SRC_BASE_MASK = 8'h7f;

   // output routing source codes (high byte)
   localparam logic [7:0] OSRC_ONE      = 8'h00;
   localparam logic [7:0] OSRC_ZERO     = 8'h01;
   localparam logic [7:0] OSRC_PWM      = 8'h10;
   localparam logic [7:0] OSRC_PWM_INV  = 8'h11;
   localparam logic [7:0] CTRL_INV_BIT  = 8'h80;
   localparam int         CTRL_IDX_W    = 5;

   localparam int BIT_BRAKE     = 0;
   localparam int BIT_INTERLOCK = 3;
   localparam int LEVEL_BASE    = 16;

   typedef struct packed {
      logic [2:0] hall;
      logic       enc_a;
      logic       enc_b;
      logic       enc_idx;
      logic       net_active;
      logic       pwm;
   } aux_sig_t;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage

// [hdl/dio_in_select.sv]
// Purpose: one routed input summary bit from an 8-bit source code
// Assumes: sources already sampled on the input tick
// Notes:   unknown codes read as zero (one when inverted)
`timescale 1ns/1ns
module dio_in_select (
   // selection
   input  wire logic [7:0]             code_in,
   input  wire logic [15:0]            phys_in,
   input  wire dio_pkg::aux_sig_t      aux_in,
   // result
   output logic                        bit_out
);
   import dio_pkg::*;
   logic [7:0] base;
   logic       raw;
   always_comb begin
      base = code_in & SRC_BASE_MASK;
      raw  = 1'b0;
      if (base >= 8'h01 && base <= SRC_PHYS_LAST) begin
         raw = phys_in[4'(base - 8'h01)];
      end else if (base >= SRC_HALL_U && base <= SRC_ENC_IDX) begin
         case (base - SRC_HALL_U)
            8'h00: raw = aux_in.hall[0];
            8'h01: raw = aux_in.hall[1];
            8'h02: raw = aux_in.hall[2];
            8'h03: raw = aux_in.enc_a;
            8'h04: raw = aux_in.enc_b;
            default: raw = aux_in.enc_idx;
         endcase
      end else if (base == SRC_NET) begin
         raw = aux_in.net_active;
      end
      bit_out = raw ^ code_in[7];
   end
endmodule

// [hdl/dio_out_route.sv]
// Purpose: one routed output driven by source and gating control bit
// Assumes: control index refers to the low 32 bits of the output word
// Notes:   encoder divider sources are not part of this stage, read as zero
`timescale 1ns/1ns
module dio_out_route (
   // configuration
   input  wire logic [15:0]  entry_in,
   input  wire logic [31:0]  out_word_in,
   input  wire logic         pwm_in,
   // result
   output logic              level_out
);
   import dio_pkg::*;
   logic [7:0] src;
   logic [7:0] ctl;
   logic       gate;
   logic       sig;
   always_comb begin
      src  = entry_in[15:8];
      ctl  = entry_in[7:0];
      gate = out_word_in[ctl[CTRL_IDX_W-1:0]] ^ ctl[7];
      case (src)
         OSRC_ONE:     sig = 1'b1;
         OSRC_ZERO:    sig = 1'b0;
         OSRC_PWM:     sig = pwm_in;
         OSRC_PWM_INV: sig = ~pwm_in;
         default:      sig = 1'b0;
      endcase
      level_out = sig & gate;
   end
endmodule

// [dv/dio_far_side.sv]
// Purpose: far side of the io stage: switches, sensors, pulled-up loads
// Assumes: the bench holds each switch level for several sample periods
// Notes:   an output that is not pulled low rises through its pull-up
`timescale 1ns/1ns
module dio_far_side (
   // bench side
   input  wire logic [15:0]       sw_in,
   input  wire dio_pkg::aux_sig_t sens_in,
   output logic [3:0]             load_out,
   // device side
   input  wire logic [3:0]        pin_oe_in,
   output logic [15:0]            pins_out,
   output dio_pkg::aux_sig_t      aux_out
);
   import dio_pkg::*;
   assign pins_out = sw_in;
   assign aux_out  = sens_in;
   // open drain: released pin reads high, never a stale value
   assign load_out = ~pin_oe_in;
endmodule

// [dv/tb_top.sv]
// Purpose: self-checking bench for the digital io routing stage
// Assumes: apb slave answers with pready; sample tick shortened to 8 cycles
// Notes:   pin levels are judged at the pulled-up loads of the far side
`timescale 1ns/1ns
module tb_top;
   import dio_pkg::*;
   localparam int SC = 8;
   logic        clk_sys_in = 1'b0;
   logic        rst_b_in   = 1'b0;
   logic        fault_in   = 1'b0;
   apb_req_t    apb_in     = '0;
   apb_rsp_t    apb_out;
   logic [15:0] sw         = 16'h0000;
   aux_sig_t    sens       = '0;
   logic [15:0] pins;
   aux_sig_t    aux;
   logic [3:0]  oe;
   logic [3:0]  lvl;
   logic        brake, mok, frx, lg, lr, err;
   logic [31:0] rd, s, e;
   int          n_fail  = 0;
   int          checked = 0;
   logic [7:0]  code [16] = '{8'h00, 8'h01, 8'h05, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44,
                              8'h45, 8'h46, 8'h48, 8'h80, 8'h81, 8'h8a, 8'hc1, 8'hc8};
   logic [15:0] re [5]    = '{16'h0005, 16'h0005, 16'h0085, 16'h0105, 16'h1105};
   logic [31:0] rw [5]    = '{32'h21, 32'h0, 32'h0, 32'h20, 32'h20};
   logic        rx [5]    = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   always #4 clk_sys_in = ~clk_sys_in;

   dio_routing #(.SAMPLE_CYC(SC)) i_dio_routing (
      .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .apb_in(apb_in), .apb_out(apb_out),
      .pins_in(pins), .aux_in(aux), .fault_in(fault_in), .pin_oe_out(oe),
      .brake_out(brake), .motion_ok_out(mok), .fault_react_out(frx),
      .led_green_out(lg), .led_red_out(lr));

   dio_far_side i_dio_far_side (
      .sw_in(sw), .sens_in(sens), .load_out(lvl), .pin_oe_in(oe), .pins_out(pins),
      .aux_out(aux));

   task final_report;
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // hold the request until pready is seen high at a rising edge
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      apb_in <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
      @(posedge clk_sys_in);
      apb_in.penable <= 1'b1;
      @(posedge clk_sys_in);
      while (apb_out.pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_sys_in);
      end
      // a slave that never answers counts as a mismatch
      if (n >= 50) begin
         n_fail++;
      end
      rd = apb_out.prdata;
      err = apb_out.pslverr;
      apb_in.psel <= 1'b0;
      apb_in.penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task tick;
      repeat (3 * SC) @(posedge clk_sys_in);
   endtask

   task outchk(input logic b, input logic [3:0] l);
      repeat (2) @(posedge clk_sys_in);
      chk({27'h0, brake, lvl}, {27'h0, b, l});
   endtask

   task led_chk(input logic f, input logic [1:0] c, input logic eg, input logic er);
      logic g, r;
      g = 1'b0;
      r = 1'b0;
      fault_in <= f;
      wr(OFF_LED_CTRL, {30'h0, c});
      // led drives lag the control write by one cycle
      @(posedge clk_sys_in);
      repeat (9000) begin
         @(posedge clk_sys_in);
         g = g | lg;
         r = r | lr;
      end
      chk({30'h0, g, r}, {30'h0, eg, er});
   endtask

   function automatic logic src(input logic [7:0] c, input logic [15:0] p, input aux_sig_t a);
      logic b;
      case (c[6:0])
         7'h41: b = a.hall[0];
         7'h42: b = a.hall[1];
         7'h43: b = a.hall[2];
         7'h44: b = a.enc_a;
         7'h45: b = a.enc_b;
         7'h46: b = a.enc_idx;
         7'h48: b = a.net_active;
         default: b = 1'b0;
      endcase
      if (c[6:0] inside {[7'h01:7'h10]})
         b = p[c[3:0] - 4'h1];
      return b ^ c[7];
   endfunction

   initial begin
      // tests need about 28000 cycles, mostly the three led windows
      repeat (40000) @(posedge clk_sys_in);
      n_fail++;
      final_report;
   end

   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      outchk(1'b0, 4'h0);
      xfer(1'b0, 12'h0fc, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      xfer(1'b0, OFF_OUT_UNUSED, 32'h0);
      chk({31'h0, err}, 32'h1);
      xfer(1'b0, OFF_OUT_ROUTE_BASE, 32'h0);
      chk(rd, 32'h0000_ffff);
      wr(OFF_OUT_WORD, 32'h0003_0001);
      outchk(1'b1, 4'h3);
      xfer(1'b0, OFF_OUT_APPLIED, 32'h0);
      chk(rd, 32'h0003_0001);
      wr(OFF_OUT_INVERT, 32'h0001_0000);
      outchk(1'b1, 4'h2);
      xfer(1'b0, OFF_OUT_APPLIED, 32'h0);
      chk(rd, 32'h0002_0001);
      wr(OFF_OUT_MAN_EN, 32'h0002_0001);
      wr(OFF_OUT_MAN_VAL, 32'h0);
      outchk(1'b0, 4'h0);
      wr(OFF_OUT_MAN_VAL, 32'h0002_0001);
      outchk(1'b1, 4'h2);
      wr(OFF_OUT_ROUTING_EN, 32'h1);
      for (int i = 0; i < 5; i++) begin
         wr(OFF_OUT_ROUTE_BASE, {16'h0, re[i]});
         wr(OFF_OUT_WORD, rw[i]);
         outchk(rw[i][0], {3'b000, rx[i]});
      end
      wr(OFF_OUT_ROUTING_EN, 32'h0);
      wr(OFF_OUT_MAN_EN, 32'h0);
      sw <= 16'h0008;
      wr(OFF_IN_SPECIAL_EN, 32'h8);
      tick;
      chk({30'h0, mok, frx}, 32'h2);
      sw <= 16'h0000;
      tick;
      chk({30'h0, mok, frx}, 32'h1);
      wr(OFF_IN_SPECIAL_EN, 32'h0);
      tick;
      chk({30'h0, mok, frx}, 32'h2);
      xfer(1'b0, OFF_STATUS, 32'h0);
      chk(rd, 32'h1);
      sw <= 16'h5a3c;
      sens <= aux_sig_t'(8'ha6);
      tick;
      xfer(1'b0, OFF_IN_SUMMARY, 32'h0);
      s = rd;
      // switched on once and left on, so the mapping never toggles back
      wr(OFF_IN_ROUTING_EN, 32'h1);
      tick;
      xfer(1'b0, OFF_IN_SUMMARY, 32'h0);
      chk(rd, s);
      wr(OFF_IN_INVERT, 32'hffff);
      wr(OFF_IN_FORCE_EN, 32'hffff);
      for (int k = 0; k < 16; k++)
         wr(12'(OFF_IN_ROUTE_BASE + 4 * k), {24'h0, code[k]});
      for (int p = 0; p < 2; p++) begin
         sw <= p ? 16'ha5c3 : 16'h5a3c;
         sens <= aux_sig_t'(p ? 8'h59 : 8'ha6);
         tick;
         e = 32'h0;
         for (int k = 0; k < 16; k++)
            e[k] = src(code[k], sw, sens);
         xfer(1'b0, OFF_IN_SUMMARY, 32'h0);
         chk(rd & 32'hffff, e);
      end
      led_chk(1'b0, 2'h3, 1'b1, 1'b0);
      led_chk(1'b1, 2'h3, 1'b0, 1'b1);
      led_chk(1'b0, 2'h0, 1'b0, 1'b0);
      final_report;
   end
endmodule
